// file: qss_pkg.sv
/*
 Package for the quad supply output supervisor: register offsets, field
 positions and time constants shared by the design and its bench.
 Assumes a 20 MHz core clock; all delays come from one 1 us time base.
*/
package qss_pkg;

    localparam int unsigned CLK_HZ          = 20_000_000;
    localparam int unsigned TICK_US         = 1;
    localparam int unsigned TICK_CYC        = CLK_HZ / 1_000_000 * TICK_US;

    localparam logic [7:0] ADDR_FAULT_WIN   = 8'h0a;
    localparam logic [7:0] ADDR_GATE_DLY    = 8'h0f;
    localparam logic [7:0] ADDR_GOOD_THR    = 8'h10;
    localparam logic [7:0] ADDR_CTRL        = 8'h20;
    localparam logic [7:0] ADDR_STATUS      = 8'h21;
    localparam logic [7:0] ADDR_TIMING      = 8'h22;

    localparam int unsigned GATE_LSB        = 5;
    localparam int unsigned PU_WIN_LSB      = 6;
    localparam int unsigned PD_WIN_LSB      = 4;

    // control register bits
    localparam int unsigned CTRL_ON         = 0;
    localparam int unsigned CTRL_DISCH_EN   = 1;
    localparam int unsigned CTRL_LEADER     = 2;
    localparam int unsigned CTRL_RETRY      = 3;
    localparam int unsigned CTRL_OC_LSB     = 4;

    localparam logic [7:0] RST_CTRL         = 8'h00;
    localparam logic [7:0] RST_CFG          = 8'h00;

    // gate-delay table in microseconds
    localparam int unsigned GATE_US [8] = '{25, 12_500, 25_000, 50_000,
                                            100_000, 200_000, 400_000,
                                            1_600_000};
    localparam int unsigned WIN_US  [4] = '{25_000, 50_000, 100_000,
                                            200_000};
    localparam int unsigned TICKW   = 21;

    typedef enum logic [5:0]
    {
        QSS_IDLE    = 6'b000001,
        QSS_GDLY    = 6'b000010,
        QSS_RAMP    = 6'b000100,
        QSS_ON      = 6'b001000,
        QSS_DOWN    = 6'b010000,
        QSS_RETRY   = 6'b100000
    } qss_state_t;

    typedef struct packed
    {
        logic [3:0] in_ok;
        logic [3:0] out_lag;
        logic [3:0] out_trk_err;
        logic [3:0] out_good;
        logic [3:0] out_low;
        logic [3:0] out_oc;
        logic [3:0] ramp_done;
    } qss_analog_t;

    typedef struct packed
    {
        logic [3:0] gate_on;
        logic [3:0] disch_on;
        logic       ramp_run;
        logic       ramp_down;
    } qss_drive_t;

endpackage

// file: qss_supervisor.sv
/*
 Output supervision logic of the quad supply tracker: start decision,
 gate delays, ramp pause, fault windows and open-drain status pins.
 Analog comparator results arrive asynchronously and are synchronised
 here; shared open-drain pins are split into input and enable.
*/
module qss_supervisor #(
    parameter int unsigned GOOD_DLY_US  = 10_000,
    parameter int unsigned OC_DLY_US    = 12_500,
    parameter int unsigned RETRY_US     = 100_000,
    parameter int unsigned TICK_DIV     = qss_pkg::TICK_CYC
) (
    input  wire logic                core_clk,
    input  wire logic                rstn,
    input  wire logic [7:0]          reg_addr,
    input  wire logic [7:0]          reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output logic      [7:0]          reg_rdata,
    input  wire logic                internal_supply_ok,
    input  wire logic                track_enable_level,
    input  wire logic                enable_in,
    input  wire logic                manual_reset_n,
    input  wire qss_pkg::qss_analog_t ana_in,
    output qss_pkg::qss_drive_t      drive,
    input  wire logic                fault_in,
    output logic                     fault_oe,
    input  wire logic                ramp_sync_line_in,
    output logic                     ramp_sync_line_oe,
    output logic      [3:0]          output_good_flag_oe,
    output logic                     removal_safe_oe,
    output logic                     overdraw_alarm_n_oe,
    output logic                     reset_out_oe
);

    typedef struct packed
    {
        logic [2:0]             s1;
        logic [2:0]             s2;
        logic                   fl1;
        logic                   fl2;
        logic                   sy1;
        logic                   sy2;
        qss_pkg::qss_analog_t   a1;
        qss_pkg::qss_analog_t   a2;
        logic [7:0]             win_q;
        logic [7:0]             gate_q;
        logic [7:0]             thr_q;
        logic [7:0]             ctrl_q;
        logic [7:0]             rdata_q;
        logic [7:0]             tdiv_q;
        logic                   tick_q;
        qss_pkg::qss_state_t    st_q;
        logic [qss_pkg::TICKW-1:0] tmr_q;
        logic [3:0][qss_pkg::TICKW-1:0] good_cnt_q;
        logic [qss_pkg::TICKW-1:0] oc_cnt_q;
        logic [qss_pkg::TICKW-1:0] rst_cnt_q;
        logic                   fault_q;
        logic                   stall_q;
        qss_pkg::qss_drive_t    drv_q;
        logic [3:0]             good_q;
        logic                   rem_q;
        logic                   oc_q;
        logic                   rst_q;
    } qss_regs_t;

    qss_regs_t r_q;
    qss_regs_t r_d;

    function automatic logic [qss_pkg::TICKW-1:0] win_ticks(
        input logic [1:0] code);
        win_ticks = qss_pkg::TICKW'(qss_pkg::WIN_US[code]
                    / qss_pkg::TICK_US);
    endfunction

    function automatic logic [qss_pkg::TICKW-1:0] gate_ticks(
        input logic [2:0] code);
        gate_ticks = qss_pkg::TICKW'(qss_pkg::GATE_US[code]
                     / qss_pkg::TICK_US);
    endfunction

    function automatic logic [qss_pkg::TICKW-1:0] bump(
        input logic [qss_pkg::TICKW-1:0] cnt,
        input logic                      cond,
        input logic                      tick);
        if (!cond)
        begin
            bump = '0;
        end
        else if (tick && cnt != '1)
        begin
            bump = cnt + 1'b1;
        end
        else
        begin
            bump = cnt;
        end
    endfunction

    localparam logic [qss_pkg::TICKW-1:0] GOOD_T =
        qss_pkg::TICKW'(GOOD_DLY_US / qss_pkg::TICK_US);
    localparam logic [qss_pkg::TICKW-1:0] OC_T =
        qss_pkg::TICKW'(OC_DLY_US / qss_pkg::TICK_US);
    localparam logic [qss_pkg::TICKW-1:0] RETRY_T =
        qss_pkg::TICKW'(RETRY_US / qss_pkg::TICK_US);
    localparam logic [qss_pkg::TICKW-1:0] RSTHOLD_T =
        qss_pkg::TICKW'(qss_pkg::WIN_US[0] / qss_pkg::TICK_US);

    always_comb
    begin
        logic       en_int;
        logic       start_ok;
        logic       peer_fault;
        logic       trk_err;
        logic       lag;
        logic       all_good;
        logic       oc_any;
        logic [3:0] sel_good;
        r_d         = r_q;
        en_int      = 1'b0;
        start_ok    = 1'b0;
        peer_fault  = 1'b0;
        trk_err     = 1'b0;
        lag         = 1'b0;
        all_good    = 1'b0;
        oc_any      = 1'b0;
        sel_good    = 4'h0;

        // two-flop synchronisers
        r_d.s1  = {internal_supply_ok, track_enable_level, enable_in};
        r_d.s2  = r_q.s1;
        r_d.fl1 = fault_in;
        r_d.fl2 = r_q.fl1;
        r_d.sy1 = manual_reset_n;
        r_d.sy2 = r_q.sy1;
        r_d.a1  = ana_in;
        r_d.a2  = r_q.a1;

        // register port, read data one cycle later
        r_d.rdata_q = 8'h00;
        if (reg_wr)
        begin
            unique case (reg_addr)
                qss_pkg::ADDR_FAULT_WIN: r_d.win_q  = reg_wdata;
                qss_pkg::ADDR_GATE_DLY:  r_d.gate_q = reg_wdata;
                qss_pkg::ADDR_GOOD_THR:  r_d.thr_q  = reg_wdata;
                qss_pkg::ADDR_CTRL:      r_d.ctrl_q = reg_wdata;
                default:                 r_d.ctrl_q = r_q.ctrl_q;
            endcase
        end
        if (reg_rd)
        begin
            unique case (reg_addr)
                qss_pkg::ADDR_FAULT_WIN: r_d.rdata_q = r_q.win_q;
                qss_pkg::ADDR_GATE_DLY:  r_d.rdata_q = r_q.gate_q;
                qss_pkg::ADDR_GOOD_THR:  r_d.rdata_q = r_q.thr_q;
                qss_pkg::ADDR_CTRL:      r_d.rdata_q = r_q.ctrl_q;
                qss_pkg::ADDR_STATUS:    r_d.rdata_q = {r_q.good_q,
                    r_q.rst_q, r_q.oc_q, r_q.stall_q, r_q.fault_q};
                qss_pkg::ADDR_TIMING:    r_d.rdata_q = {2'h0, r_q.st_q};
                default:                 r_d.rdata_q = 8'h00;
            endcase
        end

        // single time base
        r_d.tick_q = 1'b0;
        if (r_q.tdiv_q == 8'(TICK_DIV - 1))
        begin
            r_d.tdiv_q = 8'h00;
            r_d.tick_q = 1'b1;
        end
        else
        begin
            r_d.tdiv_q = r_q.tdiv_q + 8'h01;
        end

        en_int   = r_q.s2[0] & r_q.s2[1]
                   & r_q.ctrl_q[qss_pkg::CTRL_ON];
        start_ok = r_q.s2[2] & en_int & (&r_q.a2.in_ok);
        peer_fault = ~r_q.fl2 & ~r_q.fault_q;
        trk_err  = |r_q.a2.out_trk_err;
        lag      = |r_q.a2.out_lag;

        r_d.tmr_q = r_q.tmr_q + (r_q.tick_q ? 1'b1 : 1'b0);
        unique case (r_q.st_q)
            qss_pkg::QSS_IDLE:
            begin
                r_d.drv_q = '0;
                r_d.tmr_q = '0;
                // latched fault blocks restart until enable toggles
                if (start_ok && !peer_fault && !r_q.fault_q)
                begin
                    r_d.st_q = qss_pkg::QSS_GDLY;
                end
            end
            qss_pkg::QSS_GDLY:
            begin
                if (!start_ok || peer_fault)
                begin
                    r_d.st_q  = qss_pkg::QSS_DOWN;
                    r_d.tmr_q = '0;
                end
                else if (r_q.tmr_q >= gate_ticks(
                         r_q.gate_q[qss_pkg::GATE_LSB +: 3]))
                begin
                    r_d.st_q  = qss_pkg::QSS_RAMP;
                    r_d.tmr_q = '0;
                end
            end
            qss_pkg::QSS_RAMP:
            begin
                r_d.drv_q.gate_on  = 4'hf;
                r_d.drv_q.ramp_run = ~lag;
                if (trk_err || peer_fault || r_q.tmr_q >= win_ticks(
                    r_q.win_q[qss_pkg::PU_WIN_LSB +: 2]))
                begin
                    r_d.fault_q = ~peer_fault;
                    r_d.st_q    = qss_pkg::QSS_DOWN;
                    r_d.tmr_q   = '0;
                end
                else if (!start_ok)
                begin
                    r_d.st_q  = qss_pkg::QSS_DOWN;
                    r_d.tmr_q = '0;
                end
                else if (&r_q.a2.ramp_done)
                begin
                    r_d.st_q = qss_pkg::QSS_ON;
                end
            end
            qss_pkg::QSS_ON:
            begin
                r_d.drv_q.ramp_run = 1'b0;
                if (!start_ok || peer_fault)
                begin
                    r_d.st_q  = qss_pkg::QSS_DOWN;
                    r_d.tmr_q = '0;
                end
            end
            qss_pkg::QSS_DOWN:
            begin
                r_d.drv_q.ramp_down = 1'b1;
                r_d.drv_q.ramp_run  = 1'b0;
                r_d.drv_q.gate_on   = 4'h0;
                r_d.drv_q.disch_on  =
                    {4{r_q.ctrl_q[qss_pkg::CTRL_DISCH_EN]}};
                if ((&r_q.a2.out_low) || r_q.tmr_q >= win_ticks(
                    r_q.win_q[qss_pkg::PD_WIN_LSB +: 2]))
                begin
                    r_d.drv_q = '0;
                    r_d.tmr_q = '0;
                    r_d.st_q  = (r_q.fault_q &&
                                 r_q.ctrl_q[qss_pkg::CTRL_RETRY])
                                ? qss_pkg::QSS_RETRY : qss_pkg::QSS_IDLE;
                end
            end
            qss_pkg::QSS_RETRY:
            begin
                if (r_q.tmr_q >= RETRY_T)
                begin
                    r_d.fault_q = 1'b0;
                    r_d.st_q    = qss_pkg::QSS_IDLE;
                end
            end
            default:
            begin
                r_d.st_q = qss_pkg::QSS_IDLE;
            end
        endcase
        // latched fault clears on enable toggle
        if (r_q.st_q == qss_pkg::QSS_IDLE && !en_int)
        begin
            r_d.fault_q = 1'b0;
        end

        // good flags, threshold code chosen in analog per channel
        for (int i = 0; i < 4; i++)
        begin
            r_d.good_cnt_q[i] = bump(r_q.good_cnt_q[i],
                r_q.a2.out_good[i], r_q.tick_q);
            r_d.good_q[i] = r_q.good_cnt_q[i] > GOOD_T;
            sel_good[i] = r_q.a2.out_good[i];
        end
        r_d.rem_q = &r_q.a2.out_low;

        oc_any = (r_q.st_q == qss_pkg::QSS_ON) &&
                 |(r_q.a2.out_oc & r_q.ctrl_q[qss_pkg::CTRL_OC_LSB +: 4]);
        r_d.oc_cnt_q = bump(r_q.oc_cnt_q, oc_any, r_q.tick_q);
        r_d.oc_q = (r_q.oc_cnt_q > OC_T)
                   && (r_q.st_q == qss_pkg::QSS_ON);

        all_good = (r_q.st_q == qss_pkg::QSS_ON) && (&sel_good)
                   && r_q.sy2;
        r_d.rst_cnt_q = bump(r_q.rst_cnt_q, all_good, r_q.tick_q);
        r_d.rst_q = r_q.rst_cnt_q >= RSTHOLD_T;

        r_d.stall_q = r_q.ctrl_q[qss_pkg::CTRL_LEADER]
            ? (r_q.st_q == qss_pkg::QSS_RETRY)
            : (lag || !(&r_q.a2.in_ok));
    end

    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            r_q        <= '0;
            r_q.st_q   <= qss_pkg::QSS_IDLE;
            r_q.ctrl_q <= qss_pkg::RST_CTRL;
            r_q.win_q  <= qss_pkg::RST_CFG;
            r_q.gate_q <= qss_pkg::RST_CFG;
            r_q.thr_q  <= qss_pkg::RST_CFG;
            r_q.fl1    <= 1'b1;
            r_q.fl2    <= 1'b1;
        end
        else
        begin
            r_q <= r_d;
        end
    end

    assign reg_rdata           = r_q.rdata_q;
    assign drive               = r_q.drv_q;
    assign fault_oe            = r_q.fault_q;
    assign ramp_sync_line_oe   = r_q.stall_q;
    assign output_good_flag_oe = ~r_q.good_q;
    assign removal_safe_oe     = ~r_q.rem_q;
    assign overdraw_alarm_n_oe = r_q.oc_q;
    assign reset_out_oe        = ~r_q.rst_q;

endmodule

// file: qss_partner.sv
/*
 Far-side model: four switched rails following the gate drive.
 Assumes one rail step per clock, 0 to 100 percent.
*/
module qss_partner (
    input  wire logic                core_clk,
    input  wire qss_pkg::qss_drive_t drive,
    input  wire logic [3:0]          lag_hold,
    input  wire logic [3:0]          in_ok,
    input  wire logic [3:0]          trk_err,
    input  wire logic [3:0]          oc,
    output qss_pkg::qss_analog_t     ana_in
);
    timeunit 1ns;
    timeprecision 1ps;
    int rail [4];

    // a lagging rail holds; discharge quickens decay
    always @(posedge core_clk)
        for (int i = 0; i < 4; i++)
            if (!drive.gate_on[i] || drive.ramp_down)
                rail[i] <= (rail[i] > 4) ?
                    rail[i] - (drive.disch_on[i] ? 4 : 1) : 0;
            else if (drive.ramp_run && !lag_hold[i] && rail[i] < 100)
                rail[i] <= rail[i] + 1;

    always_comb
    begin
        ana_in = {in_ok, lag_hold, trk_err, 4'h0, 4'h0, oc, 4'h0};
        for (int i = 0; i < 4; i++)
        begin
            ana_in.out_good[i] = rail[i] >= 90;
            ana_in.out_low[i] = rail[i] < 10;
            ana_in.ramp_done[i] = rail[i] >= 100;
        end
    end
endmodule

// file: qss_assertions.sv
/*
 Port-level timing checks of the supervisor.
 Assumes one clock domain and a synchronous active-low reset.
*/
module qss_assertions #(
    parameter int unsigned GOOD_DLY_US = 10_000,
    parameter int unsigned TICK_DIV    = 20
) (
    input wire logic                 core_clk,
    input wire logic                 rstn,
    input wire logic                 internal_supply_ok,
    input wire logic                 track_enable_level,
    input wire logic                 enable_in,
    input wire logic                 manual_reset_n,
    input wire qss_pkg::qss_analog_t ana_in,
    input wire qss_pkg::qss_drive_t  drive,
    input wire logic                 fault_in,
    input wire logic [3:0]           output_good_flag_oe,
    input wire logic                 removal_safe_oe,
    input wire logic                 overdraw_alarm_n_oe,
    input wire logic                 reset_out_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    logic [31:0] good_run_q;

    // cycles channel one has stayed good
    always_ff @(posedge core_clk)
        if (!rstn || !ana_in.out_good[0])
            good_run_q <= 32'h0;
        else if (good_run_q != 32'hffffffff)
            good_run_q <= good_run_q + 32'h1;

    sequence start_blocked;
        !(internal_supply_ok && track_enable_level && enable_in
          && (&ana_in.in_ok)) [*5];
    endsequence
    sequence lag_seen;
        (|ana_in.out_lag) [*5];
    endsequence
    sequence mr_held;
        !manual_reset_n [*5];
    endsequence

    no_start_a: assert property (
        start_blocked |-> !$rose(|drive.gate_on))
        else $error("gate rose with a start term false");
    ramp_pause_a: assert property (
        lag_seen |-> !drive.ramp_run)
        else $error("ramp ran while an output lagged");
    disch_down_a: assert property (
        (|drive.disch_on) |-> !drive.ramp_run)
        else $error("discharge on while ramping up");
    peer_stop_a: assert property (
        !fault_in [*5] |-> !drive.ramp_run)
        else $error("ramp ran with fault line low");
    good_delay_a: assert property (
        $fell(output_good_flag_oe[0]) |-> good_run_q > GOOD_DLY_US * TICK_DIV)
        else $error("good flag released early");
    removal_low_a: assert property (
        (ana_in.out_low != 4'hf) [*5] |-> removal_safe_oe)
        else $error("removal released with an output high");
    oc_cause_a: assert property (
        $rose(overdraw_alarm_n_oe)
        |-> $past(ana_in.out_oc, 4) != 4'h0 && !drive.ramp_down)
        else $error("overdraw alarm without cause");
    mr_reset_a: assert property (
        mr_held |-> reset_out_oe)
        else $error("reset released during manual reset");
endmodule

bind qss_supervisor qss_assertions #(
    .GOOD_DLY_US(GOOD_DLY_US), .TICK_DIV(TICK_DIV)
) u_qss_assertions (
    .core_clk(core_clk), .rstn(rstn), .enable_in(enable_in),
    .internal_supply_ok(internal_supply_ok), .ana_in(ana_in),
    .track_enable_level(track_enable_level), .drive(drive),
    .manual_reset_n(manual_reset_n), .fault_in(fault_in),
    .output_good_flag_oe(output_good_flag_oe),
    .removal_safe_oe(removal_safe_oe), .reset_out_oe(reset_out_oe),
    .overdraw_alarm_n_oe(overdraw_alarm_n_oe)
);

// file: tb.sv
/*
 Self-checking bench: register model, start, ramp, good, reset,
 overdraw, power-down and fault runs. Assumes one tick per clock.
*/
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HOLD = 25_000;
    localparam int GDLY = 20;
    localparam int OCD  = 30;
    localparam int SL   = 12;

    logic       core_clk, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic       internal_supply_ok = 1'b0, track_enable_level = 1'b1;
    logic       enable_in = 1'b1, manual_reset_n = 1'b1, peer_flt = 1'b0;
    logic [3:0] lag_hold = 4'h0, in_ok = 4'hf, trk_err = 4'h0, oc = 4'h0;
    logic       fault_w, fault_oe, sync_oe, rem_oe, oc_oe, rst_oe;
    logic [3:0] good_oe;
    logic       disch_seen = 1'b0;
    logic [7:0] mdl [256];
    logic [7:0] amap [5] = '{8'h0a, 8'h0f, 8'h10, 8'h20, 8'h33};
    logic [31:0] rng = 32'h9ccf4862;
    int         err_count = 0, check_count = 0, t;
    qss_pkg::qss_analog_t ana_in;
    qss_pkg::qss_drive_t  drive;

    assign fault_w = !(fault_oe || peer_flt);

    qss_supervisor #(
        .GOOD_DLY_US(GDLY), .OC_DLY_US(OCD), .RETRY_US(5), .TICK_DIV(1)
    ) u_qss_supervisor (
        .core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .internal_supply_ok(internal_supply_ok),
        .track_enable_level(track_enable_level), .enable_in(enable_in),
        .manual_reset_n(manual_reset_n), .ana_in(ana_in), .drive(drive),
        .fault_in(fault_w), .fault_oe(fault_oe),
        .ramp_sync_line_in(!sync_oe), .ramp_sync_line_oe(sync_oe),
        .output_good_flag_oe(good_oe), .removal_safe_oe(rem_oe),
        .overdraw_alarm_n_oe(oc_oe), .reset_out_oe(rst_oe)
    );
    qss_partner u_qss_partner (
        .core_clk(core_clk), .drive(drive), .lag_hold(lag_hold),
        .in_ok(in_ok), .trk_err(trk_err), .oc(oc), .ana_in(ana_in)
    );

    initial
    begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    always @(posedge core_clk)
        if (|drive.disch_on)
            disch_seen <= 1'b1;

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    task automatic close_out;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_rng(input int got, input int lo, input int hi);
        check_count++;
        if (got < lo || got > hi)
        begin
            err_count++;
            $display("mismatch at %0t: took %h want %h", $time, got, lo);
        end
    endtask

    // step past the k-th next edge so outputs have settled
    task automatic cyc(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        cyc(1);
        reg_wr <= 1'b0;
        if (a != 8'h33)
            mdl[a] = d;
        cyc(1);
    endtask

    task automatic rd(input logic [7:0] a);
        reg_addr <= a;
        reg_rd <= 1'b1;
        cyc(1);
        reg_rd <= 1'b0;
        chk(reg_rdata, mdl[a]);
        cyc(1);
    endtask

    function automatic bit met(input int s);
        case (s)
            0: return (|drive.gate_on) === 1'b1;
            1: return good_oe === 4'h0;
            2: return rst_oe === 1'b0;
            3: return oc_oe === 1'b1;
            4: return rem_oe === 1'b0;
            5: return fault_oe === 1'b1;
            7: return sync_oe === 1'b1;
            default: return drive.gate_on === 4'h0;
        endcase
    endfunction

    task automatic wt(input int s, input int lim);
        for (t = 0; t < lim && !met(s); t++)
            cyc(1);
        if (t == lim)
        begin
            err_count++;
            close_out();
        end
    endtask

    initial
    begin
        foreach (mdl[i]) mdl[i] = 8'h00;
        cyc(2);
        rstn <= 1'b1;
        cyc(1);
        chk({good_oe, rem_oe, oc_oe, rst_oe, fault_oe}, 32'hfa);
        foreach (amap[i]) rd(amap[i]);
        repeat (3)
            foreach (amap[i])
            begin
                rng = xs(rng);
                wr(amap[i], rng[7:0]);
                rd(amap[i]);
            end
        wr(qss_pkg::ADDR_FAULT_WIN, 8'h00);
        wr(qss_pkg::ADDR_GATE_DLY, 8'h00);
        wr(qss_pkg::ADDR_CTRL, 8'h13);
        cyc(100);
        chk(drive.gate_on, 4'h0);
        internal_supply_ok <= 1'b1;
        wt(0, 200);
        chk_rng(t, qss_pkg::GATE_US[0], qss_pkg::GATE_US[0] + SL);
        lag_hold <= 4'h4;
        cyc(40);
        chk(sync_oe, 1'b1);
        lag_hold <= 4'h0;
        wt(1, 2000);
        chk(rem_oe, 1'b1);
        wt(2, HOLD + 200);
        chk_rng(t, HOLD - GDLY - 2 * SL, HOLD + SL);
        chk(sync_oe, 1'b0);
        mdl[qss_pkg::ADDR_STATUS] = 8'hf8;
        rd(qss_pkg::ADDR_STATUS);
        mdl[qss_pkg::ADDR_TIMING] = {2'h0, qss_pkg::QSS_ON};
        rd(qss_pkg::ADDR_TIMING);
        manual_reset_n <= 1'b0;
        cyc(10);
        chk(rst_oe, 1'b1);
        manual_reset_n <= 1'b1;
        wt(2, HOLD + 200);
        chk_rng(t, HOLD, HOLD + SL);
        oc <= 4'h1;
        cyc(OCD / 2);
        oc <= 4'h2;
        cyc(OCD * 2);
        chk(oc_oe, 1'b0);
        oc <= 4'h1;
        wt(3, 200);
        chk_rng(t, OCD, OCD + SL);
        oc <= 4'h0;
        enable_in <= 1'b0;
        wt(4, 2000);
        chk({disch_seen, drive.gate_on}, 32'h10);
        wr(qss_pkg::ADDR_GATE_DLY, 8'h20);
        in_ok <= 4'he;
        enable_in <= 1'b1;
        cyc(50);
        chk({sync_oe, drive.gate_on}, 32'h10);
        in_ok <= 4'hf;
        wt(0, 13_000);
        chk_rng(t, qss_pkg::GATE_US[1], qss_pkg::GATE_US[1] + SL);
        wr(qss_pkg::ADDR_CTRL, 8'h1f);
        cyc(18);
        trk_err <= 4'h1;
        wt(5, 100);
        wt(6, 1000);
        chk(drive.ramp_run, 1'b0);
        wt(7, 100);
        trk_err <= 4'h0;
        enable_in <= 1'b0;
        wt(4, 2000);
        wr(qss_pkg::ADDR_GATE_DLY, 8'h00);
        enable_in <= 1'b1;
        wt(0, 200);
        cyc(20);
        peer_flt <= 1'b1;
        wt(6, 1000);
        chk(fault_oe, 1'b0);
        close_out();
    end
endmodule
